// ---- rtl/lacms_pkg.sv ----
// Package of constants and types for the charge mode sequencer
package lacms_pkg;

  // ***************************************************************
  // Mode encoding
  // ***************************************************************
  typedef enum logic [5:0] {
    LACMS_IDLE    = 6'h01,
    LACMS_TRICKLE = 6'h02,
    LACMS_CC      = 6'h04,
    LACMS_OVCHG   = 6'h08,
    LACMS_FLOAT   = 6'h10,
    LACMS_SLEEP   = 6'h20
  } lacms_mode_e;

  // ***************************************************************
  // Comparator bundle
  // ***************************************************************
  typedef struct packed {
    logic above_lockout;  // Input above input_lockout_level
    logic input_present;  // Input above battery, sleep hysteresis
    logic bat_above_pre;  // Battery above 75% of overcharge target
    logic bat_near_oc;    // Battery near 14.8V overcharge target
    logic cur_below_end;  // Current below 38% of constant current
    logic bat_below_rech; // Battery below 83.95% of target
    logic over_voltage;   // Over-voltage comparator tripped
  } lacms_cmp_s;

  // Loop target selects handed to the analog loops
  typedef struct packed {
    logic cur_trickle;    // Current target 17.5% of full
    logic cur_full;       // Current target 0.12V across sense resistor
    logic volt_oc;        // Voltage target 14.8V
    logic volt_float;     // Voltage target 13.55V
    logic ov_float_thr;   // Over-voltage at 0.98 instead of 1.07
  } lacms_loop_s;

  localparam int LACMS_CMP_W = 7;
  localparam lacms_cmp_s LACMS_CMP_RESET = 7'h00;
  localparam lacms_loop_s LACMS_LOOP_RESET = 5'h00;
  localparam logic LACMS_GATE_OFF = 1'b0;
  // Reset level of single-bit flops: status switch open, PWM request off
  localparam logic LACMS_BIT_RESET = 1'b0;

endpackage

// ---- rtl/lacms_sync.sv ----
// Two flip-flop synchroniser for the comparator bundle
`timescale 1ns/10ps
module lacms_sync
  import lacms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire lacms_cmp_s async_in,
  output lacms_cmp_s sync_out
);

  lacms_cmp_s stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= LACMS_CMP_RESET;
      sync_out <= LACMS_CMP_RESET;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- rtl/lacms_top.sv ----
// Charge mode sequencer for a switch-mode lead-acid charger
//
// Behaviour
// - Start a cycle only when input exceeds lockout and battery voltage.
// - At start, battery below 75% of target enters trickle mode.
// - Trickle mode selects current target of about 17.5% of full.
// - Battery rising past 75% moves trickle to constant current.
// - Constant current uses the 0.12V sense reference.
// - Battery falling below 75% in constant current returns to trickle.
// - Battery near 14.8V moves constant current to overcharge.
// - Current decayed to 38% ends overcharge and enters float.
// - Float mode switches the voltage target to 13.55V.
// - Status pin pulled low in trickle, constant current, overcharge.
// - Status pin released in float mode.
// - Input removal then return from float starts a fresh cycle.
// - Float battery below 83.95% of target restarts a cycle.
// - Input absent places charger in sleep, charging stopped.
// - Over-voltage holds switch off until the condition clears.
// - Over-voltage threshold is 1.07 of target outside float.
// - Status pin released when input under lockout or battery.
`timescale 1ns/10ps
module lacms_top
  import lacms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Comparator results from the analog front end
  input wire lacms_cmp_s cmp_in,
  // PWM request from the internal oscillator and loops
  input wire logic pwm_in,
  // Gate drive to the external switch
  output logic gate_drive_out,
  // Open-drain status pin, low when driven
  output logic charge_active_out,
  output logic charge_active_oe,
  // Loop target selects and mode view
  output lacms_loop_s loop_sel,
  output lacms_mode_e mode
);

  // ***************************************************************
  // Input synchronisation
  // ***************************************************************
  lacms_cmp_s cmp;
  logic pwm_s1;
  logic pwm_s2;

  lacms_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(cmp_in),
    .sync_out(cmp)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_s1 <= LACMS_BIT_RESET;
      pwm_s2 <= LACMS_BIT_RESET;
    end
    else
    begin
      pwm_s1 <= pwm_in;
      pwm_s2 <= pwm_s1;
    end
  end

  // ***************************************************************
  // Mode sequencing
  // ***************************************************************
  lacms_mode_e next_mode;
  wire supply_ok = cmp.above_lockout & cmp.input_present;
  wire start_mode_trickle = !cmp.bat_above_pre;

  always_comb
  begin
    next_mode = mode;
    if (!cmp.above_lockout)
      next_mode = LACMS_IDLE;
    else if (!cmp.input_present)
      next_mode = LACMS_SLEEP;
    else
    begin
      case (mode)
        LACMS_IDLE, LACMS_SLEEP:
          // Re-entry after a supply loss always starts fresh
          next_mode = start_mode_trickle ? LACMS_TRICKLE : LACMS_CC;
        LACMS_TRICKLE:
          if (cmp.bat_above_pre)
            next_mode = LACMS_CC;
        LACMS_CC:
          if (!cmp.bat_above_pre)
            next_mode = LACMS_TRICKLE;
          else if (cmp.bat_near_oc)
            next_mode = LACMS_OVCHG;
        LACMS_OVCHG:
          if (cmp.cur_below_end)
            next_mode = LACMS_FLOAT;
        LACMS_FLOAT:
          if (cmp.bat_below_rech)
            next_mode = start_mode_trickle ? LACMS_TRICKLE : LACMS_CC;
        default:
          next_mode = LACMS_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Output decode
  // ***************************************************************
  wire charging = (next_mode == LACMS_TRICKLE) | (next_mode == LACMS_CC)
    | (next_mode == LACMS_OVCHG);
  wire in_float = (next_mode == LACMS_FLOAT);
  // Over-voltage is checked on the synchronised level, so the switch may
  // run two extra cycles after a trip; fine against a 315 kHz PWM
  wire next_gate = (charging | in_float) & supply_ok & !cmp.over_voltage
    & pwm_s2;
  lacms_loop_s next_loop;

  always_comb
  begin
    next_loop = LACMS_LOOP_RESET;
    next_loop.cur_trickle = (next_mode == LACMS_TRICKLE);
    next_loop.cur_full = (next_mode == LACMS_CC);
    next_loop.volt_oc = (next_mode == LACMS_OVCHG);
    next_loop.volt_float = in_float;
    next_loop.ov_float_thr = in_float;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= LACMS_IDLE;
      gate_drive_out <= LACMS_GATE_OFF;
      charge_active_oe <= LACMS_BIT_RESET;
      loop_sel <= LACMS_LOOP_RESET;
    end
    else
    begin
      mode <= next_mode;
      gate_drive_out <= next_gate;
      charge_active_oe <= charging;
      loop_sel <= next_loop;
    end
  end

  // Pin level when driven is always low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      charge_active_out <= LACMS_BIT_RESET;
    else
      charge_active_out <= 1'b0;
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  gate_ov_off_a: assert property (
    cmp.over_voltage |=> !gate_drive_out)
    else $error("Gate on during over-voltage");
  status_low_a: assert property (
    (mode == LACMS_TRICKLE || mode == LACMS_CC || mode == LACMS_OVCHG)
    |-> charge_active_oe)
    else $error("Status pin not driven while charging");
  status_float_a: assert property (
    (mode == LACMS_FLOAT) |-> !charge_active_oe)
    else $error("Status pin driven in float");
  status_supply_a: assert property (
    !supply_ok |=> !charge_active_oe && !gate_drive_out)
    else $error("Status or gate active without supply");
  sleep_entry_a: assert property (
    cmp.above_lockout && !cmp.input_present |=> mode == LACMS_SLEEP)
    else $error("Sleep not entered");
  lockout_idle_a: assert property (
    !cmp.above_lockout |=> mode == LACMS_IDLE)
    else $error("Idle not entered on lockout");
  trickle_cc_a: assert property (
    mode == LACMS_TRICKLE && supply_ok && cmp.bat_above_pre
    |=> mode == LACMS_CC && loop_sel.cur_full)
    else $error("Trickle did not advance");
  cc_back_a: assert property (
    mode == LACMS_CC && supply_ok && !cmp.bat_above_pre
    |=> mode == LACMS_TRICKLE && loop_sel.cur_trickle)
    else $error("Constant current did not fall back");
  ovchg_end_a: assert property (
    mode == LACMS_OVCHG && supply_ok && cmp.cur_below_end
    |=> mode == LACMS_FLOAT && loop_sel.volt_float)
    else $error("Overcharge did not end");
  // Supply is judged at the edge that left float, not the one after it
  recharge_status_a: assert property (
    $past(mode) == LACMS_FLOAT && mode != LACMS_FLOAT
    && $past(supply_ok) |-> charge_active_oe)
    else $error("Recharge left status released");
  start_trickle_a: assert property (
    mode == LACMS_IDLE && supply_ok && !cmp.bat_above_pre
    |=> mode == LACMS_TRICKLE)
    else $error("Start did not enter trickle");
  ovchg_entry_a: assert property (
    mode == LACMS_CC && supply_ok && cmp.bat_above_pre && cmp.bat_near_oc
    |=> mode == LACMS_OVCHG && loop_sel.volt_oc)
    else $error("Constant current did not reach overcharge");
  float_recharge_a: assert property (
    mode == LACMS_FLOAT && supply_ok && cmp.bat_below_rech
    |=> mode == LACMS_TRICKLE || mode == LACMS_CC)
    else $error("Float did not restart a cycle");
  sleep_restart_a: assert property (
    mode == LACMS_SLEEP && supply_ok
    |=> mode == LACMS_TRICKLE || mode == LACMS_CC)
    else $error("Supply return did not restart a cycle");
  gate_idle_a: assert property (
    mode == LACMS_IDLE || mode == LACMS_SLEEP |-> !gate_drive_out)
    else $error("Gate on while idle or asleep");

  full_cycle_c: cover property (
    mode == LACMS_OVCHG ##[1:200] mode == LACMS_FLOAT);
  recharge_c: cover property (
    mode == LACMS_FLOAT ##1 mode == LACMS_TRICKLE);
  ov_c: cover property (mode == LACMS_CC && cmp.over_voltage);
  sleep_c: cover property (mode == LACMS_FLOAT ##1 mode == LACMS_SLEEP);

endmodule

// ---- sim/lacms_partner.sv ----
// Model of the status pin pull-up on the far side
`timescale 1ns/10ps
module lacms_partner
  import lacms_pkg::*;
(
  // Pin drive from the sequencer
  input wire logic charge_active_out,
  input wire logic charge_active_oe,
  // Resolved pin level
  output logic status_pin
);
  // Pull-up wins whenever the switch is open
  assign status_pin = charge_active_oe ? charge_active_out : 1'b1;
endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench for the charge mode sequencer
`timescale 1ns/10ps
module tb_top;
  import lacms_pkg::*;
  // ***************************************************************
  // Signals
  // ***************************************************************
  typedef struct {
    logic [12:0] v;
    logic [12:0] m;
    int due;
  } lacms_note_s;
  logic clk;
  logic reset_n;
  logic pwm_in;
  lacms_cmp_s cmp_in;
  logic gate_drive_out;
  logic charge_active_out;
  logic charge_active_oe;
  lacms_loop_s loop_sel;
  lacms_mode_e mode;
  logic status_pin;
  logic [31:0] r;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  lacms_note_s q[$];
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  lacms_top DUT (.clk(clk), .reset_n(reset_n), .cmp_in(cmp_in),
    .pwm_in(pwm_in), .gate_drive_out(gate_drive_out),
    .charge_active_out(charge_active_out),
    .charge_active_oe(charge_active_oe), .loop_sel(loop_sel), .mode(mode));
  lacms_partner far_side (.charge_active_out(charge_active_out),
    .charge_active_oe(charge_active_oe), .status_pin(status_pin));
  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic check(input logic [12:0] seen, exp, mask);
    n_checks++;
    if (((seen ^ exp) & mask) !== 13'h0000)
    begin
      bad_count++;
      $display("wrong value outputs expected %h seen %h", exp, seen);
    end
  endtask
  // Loop selects are compared only when use_lp is set; the idle and sleep steps out of reset leave them free
  task automatic step(input lacms_cmp_s c, input logic p,
    input lacms_mode_e md, input lacms_loop_s lp, input logic pin,
    input logic g, input logic use_lp);
    lacms_note_s n;
    @(posedge clk);
    cmp_in <= c;
    pwm_in <= p;
    n.v = {md, lp, pin, g};
    n.m = {6'h3F, {5{use_lp}}, 2'h3};
    // Two sync edges and one state edge, plus a spare
    n.due = cyc + 5;
    q.push_back(n);
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ***************************************************************
  // Monitor
  // ***************************************************************
  always @(negedge clk)
  begin
    if (q.size() > 0 && q[0].due <= cyc)
    begin
      check({mode, loop_sel, status_pin, gate_drive_out}, q[0].v, q[0].m);
      q.delete(0);
    end
  end
  // ***************************************************************
  // Stimulus
  // ***************************************************************
  initial
  begin
    cmp_in = LACMS_CMP_RESET;
    pwm_in = 1'b0;
    reset_n = 1'b0;
    r = $urandom(43723);
    step(7'h70, 1'b1, LACMS_IDLE, 5'h00, 1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    // Quiet inputs at release, so no held level starts a cycle early
    cmp_in <= LACMS_CMP_RESET;
    pwm_in <= 1'b0;
    reset_n <= 1'b1;
    r = $urandom;
    step({1'b0, r[5:0]}, r[6], LACMS_IDLE, 5'h00, 1'b1, 1'b0, 1'b0);
    r = $urandom;
    step({2'b10, r[4:0]}, r[7], LACMS_SLEEP, 5'h00, 1'b1, 1'b0, 1'b0);
    step(7'h60, 1'b1, LACMS_TRICKLE, 5'h10, 1'b0, 1'b1, 1'b1);
    step(7'h60, 1'b0, LACMS_TRICKLE, 5'h10, 1'b0, 1'b0, 1'b1);
    step(7'h70, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    step(7'h60, 1'b1, LACMS_TRICKLE, 5'h10, 1'b0, 1'b1, 1'b1);
    step(7'h70, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    step(7'h71, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b0, 1'b1);
    step(7'h78, 1'b1, LACMS_OVCHG, 5'h04, 1'b0, 1'b1, 1'b1);
    step(7'h79, 1'b1, LACMS_OVCHG, 5'h04, 1'b0, 1'b0, 1'b1);
    step(7'h78, 1'b1, LACMS_OVCHG, 5'h04, 1'b0, 1'b1, 1'b1);
    step(7'h7C, 1'b1, LACMS_FLOAT, 5'h03, 1'b1, 1'b1, 1'b1);
    step(7'h72, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    step(7'h30, 1'b1, LACMS_IDLE, 5'h00, 1'b1, 1'b0, 1'b0);
    step(7'h70, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    step(7'h78, 1'b1, LACMS_OVCHG, 5'h04, 1'b0, 1'b1, 1'b1);
    step(7'h7C, 1'b1, LACMS_FLOAT, 5'h03, 1'b1, 1'b1, 1'b1);
    step(7'h5C, 1'b1, LACMS_SLEEP, 5'h00, 1'b1, 1'b0, 1'b0);
    step(7'h70, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    step(7'h78, 1'b1, LACMS_OVCHG, 5'h04, 1'b0, 1'b1, 1'b1);
    step(7'h7C, 1'b1, LACMS_FLOAT, 5'h03, 1'b1, 1'b1, 1'b1);
    step(7'h7D, 1'b1, LACMS_FLOAT, 5'h03, 1'b1, 1'b0, 1'b1);
    step(7'h62, 1'b1, LACMS_TRICKLE, 5'h10, 1'b0, 1'b1, 1'b1);
    // Reset in mid-cycle drops back to idle, then a held supply restarts
    @(posedge clk);
    reset_n <= 1'b0;
    step(7'h70, 1'b1, LACMS_IDLE, 5'h00, 1'b1, 1'b0, 1'b1);
    reset_n <= 1'b1;
    step(7'h70, 1'b1, LACMS_CC, 5'h08, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 20 && q.size() > 0; i++)
      @(posedge clk);
    if (q.size() > 0)
      bad_count++;
    close_out();
  end
endmodule
